// >>> dv/config_pin_function_select_tb.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("unexpected %s expected %h seen %h", n, e, a); end end
module config_pin_function_select_tb
    import pin_function_pkg::*;
;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, irq, err;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    opt_cfg_s option_store;
    usb_state_s usb_state;
    source_sig_s source_sig;
    logic option_pin_in, option_pin_out, option_pin_oe, vbus_present, hold_awake;
    logic ext_en, ext_lvl;
    int failures = 0;
    int n_compared = 0;
    int cyc = 0;
    config_pin_function_select dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
        .option_store(option_store), .usb_state(usb_state), .source_sig(source_sig),
        .option_pin_in(option_pin_in), .option_pin_out(option_pin_out),
        .option_pin_oe(option_pin_oe), .vbus_present(vbus_present), .hold_awake(hold_awake));
    pad_partner u_pad (.pin_out(option_pin_out), .pin_oe(option_pin_oe), .ext_en(ext_en),
        .ext_lvl(ext_lvl), .pin_in(option_pin_in));
    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end
    task automatic finish_test();
        if (failures == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : finish_test
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            failures++;
            finish_test();
        end
    end
    task automatic settle();
        repeat (3) @(posedge pclk);
        @(negedge pclk);
    endtask : settle
    task automatic pad(input logic e_oe, input logic e_out);
        `CHK("pad_oe", e_oe, option_pin_oe)
        if (e_oe) `CHK("pad_out", e_out, option_pin_out)
    endtask : pad
    task automatic opt(input pin_opt_e c, input logic cancel);
        @(posedge pclk);
        presetn <= 1'b0;
        option_store <= {cancel, c};
        usb_state <= '0;
        source_sig <= '0;
        ext_en <= 1'b0;
        @(negedge pclk);
        `CHK("reset_oe", 1'b0, option_pin_oe)
        @(posedge pclk);
        presetn <= 1'b1;
        settle();
    endtask : opt
    task automatic apb(input logic wr, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic t_const();
        opt(OPT_TRISTATE, 1'b0);
        pad(1'b0, 1'b0);
        opt(OPT_DRIVE_1, 1'b0);
        pad(1'b1, 1'b1);
        opt(OPT_DRIVE_0, 1'b0);
        pad(1'b1, 1'b0);
    endtask : t_const
    task automatic t_power();
        opt(OPT_POWER_EN, 1'b0);
        pad(1'b0, 1'b0);
        @(posedge pclk) usb_state.configured <= 1'b1;
        settle();
        pad(1'b1, 1'b0);
        @(posedge pclk) usb_state.suspended <= 1'b1;
        settle();
        `CHK("pwr_high", 1'b1, option_pin_in)
        opt(OPT_SLEEP_IND, 1'b1);
        pad(1'b1, 1'b1);
        @(posedge pclk) usb_state.suspended <= 1'b1;
        settle();
        pad(1'b1, 1'b0);
        @(posedge pclk) usb_state.charger <= 1'b1;
        settle();
        pad(1'b1, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status_sleep", 32'h6, rd)
    endtask : t_power
    task automatic t_src();
        pin_opt_e codes[5];
        int bits[5];
        codes = '{OPT_CLK_FAST, OPT_CLK_MID, OPT_CLK_SLOW, OPT_WRITE_STROBE, OPT_READ_STROBE};
        bits = '{2, 1, 0, 4, 3};
        for (int i = 0; i < 5; i++) begin
            opt(codes[i], 1'b0);
            @(posedge pclk) source_sig <= 5'h1f ^ (5'h1 << bits[i]);
            settle();
            pad(1'b1, 1'b0);
            @(posedge pclk) source_sig <= 5'h1 << bits[i];
            settle();
            pad(1'b1, 1'b1);
            @(posedge pclk) usb_state.suspended <= 1'b1;
            settle();
            pad(1'b1, i > 2);
        end
    endtask : t_src
    task automatic t_gpio();
        opt(OPT_GPIO, 1'b0);
        apb(1'b1, OFS_GPIO, 32'h3);
        settle();
        pad(1'b1, 1'b1);
        apb(1'b0, OFS_GPIO, 32'h0);
        `CHK("gpio_rd", 32'h3, rd)
        apb(1'b1, OFS_GPIO, 32'h0);
        @(posedge pclk) ext_en <= 1'b1;
        settle();
        pad(1'b0, 1'b0);
        apb(1'b1, OFS_PIN_STATE, 32'hffff);
        `CHK("ro_err", 1'b0, err)
        apb(1'b0, OFS_PIN_STATE, 32'h0);
        `CHK("pin_state", 32'h88, rd)
        apb(1'b0, 12'h010, 32'h0);
        `CHK("slverr", 1'b1, err)
    endtask : t_gpio
    task automatic t_input();
        opt(OPT_VBUS_SENSE, 1'b0);
        apb(1'b1, OFS_MASK, 32'h8);
        apb(1'b0, OFS_MASK, 32'h0);
        `CHK("mask_rd", 32'h8, rd)
        apb(1'b1, OFS_STATUS, 32'hf);
        @(posedge pclk) ext_en <= 1'b1;
        settle();
        `CHK("vbus", 1'b0, vbus_present)
        `CHK("irq_set", 1'b1, irq)
        apb(1'b1, OFS_STATUS, 32'h8);
        settle();
        `CHK("irq_clr", 1'b0, irq)
        opt(OPT_STAY_AWAKE, 1'b0);
        `CHK("awake_idle", 1'b0, hold_awake)
        @(posedge pclk) ext_en <= 1'b1;
        settle();
        `CHK("awake", 1'b1, hold_awake)
    endtask : t_input
    task automatic t_events();
        logic lv;
        opt(OPT_CHARGER_N, 1'b0);
        pad(1'b0, 1'b0);
        @(posedge pclk) usb_state.charger <= 1'b1;
        settle();
        pad(1'b1, 1'b0);
        opt(OPT_CHARGER, 1'b0);
        @(posedge pclk) usb_state.charger <= 1'b1;
        settle();
        pad(1'b1, 1'b1);
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status_chg", 32'h2, rd)
        opt(OPT_FRAME_TOGGLE, 1'b0);
        for (int i = 0; i < 2; i++) begin
            lv = option_pin_out;
            @(posedge pclk) usb_state.sof <= 1'b1;
            @(posedge pclk) usb_state.sof <= 1'b0;
            settle();
            `CHK("toggle", ~lv, option_pin_out)
        end
        lv = option_pin_out;
        @(posedge pclk) clk_en <= 1'b0;
        @(posedge pclk) usb_state.sof <= 1'b1;
        @(posedge pclk) usb_state.sof <= 1'b0;
        @(posedge pclk) clk_en <= 1'b1;
        settle();
        `CHK("frozen", lv, option_pin_out)
        apb(1'b0, OFS_STATUS, 32'h0);
        `CHK("status_sof", 32'h1, rd)
    endtask : t_events
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        option_store = '0;
        usb_state = '0;
        source_sig = '0;
        ext_en = 1'b0;
        ext_lvl = 1'b0;
        repeat (6) @(posedge pclk);
        t_const();
        t_power();
        t_src();
        t_gpio();
        t_input();
        t_events();
        finish_test();
    end
endmodule : config_pin_function_select_tb
`default_nettype wire

// >>> dv/pad_partner.sv
`timescale 1ns/1ns
`default_nettype none
module pad_partner (
    input wire logic pin_out,
    input wire logic pin_oe,
    input wire logic ext_en,
    input wire logic ext_lvl,
    output logic pin_in
);
    assign pin_in = pin_oe ? pin_out : (ext_en ? ext_lvl : 1'b1);
endmodule : pad_partner
`default_nettype wire

// >>> dv/pin_select_properties.sv
`timescale 1ns/1ns
`default_nettype none
module pin_select_properties
    import pin_function_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire opt_cfg_s option_store,
    input wire usb_state_s usb_state,
    input wire source_sig_s source_sig,
    input wire logic option_pin_in,
    input wire logic option_pin_out,
    input wire logic option_pin_oe,
    input wire logic vbus_present,
    input wire logic hold_awake
);
    logic [1:0] up_ff;
    logic on;
    logic susp;
    pin_opt_e sel;
    assign on = up_ff[1];
    assign susp = usb_state.suspended;
    assign sel = option_store.sel;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            up_ff <= 2'h0;
        end else if (up_ff != 2'h3) begin
            up_ff <= up_ff + 2'h1;
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    tri_release_a: assert property (on && sel == OPT_TRISTATE |-> !option_pin_oe)
        else $error("tristate pad driven");
    const_level_a: assert property (on && (sel == OPT_DRIVE_1 || sel == OPT_DRIVE_0)
        |-> option_pin_oe && option_pin_out == (sel == OPT_DRIVE_1)) else $error("constant wrong");
    pwr_enable_a: assert property (on && sel == OPT_POWER_EN |-> !option_pin_out
        && option_pin_oe == ($past(usb_state.configured) && !$past(susp)))
        else $error("power enable wrong");
    sleep_ind_a: assert property (on && sel == OPT_SLEEP_IND |-> option_pin_oe
        && option_pin_out == (!$past(susp) || option_store.cancel_sleep
        && $past(usb_state.charger))) else $error("sleep indicator wrong");
    clk_gate_a: assert property (on && sel == OPT_CLK_MID
        |-> option_pin_out == ($past(source_sig.clk_mid) && !$past(susp)))
        else $error("clock output wrong");
    chg_drain_a: assert property (on && sel == OPT_CHARGER_N |-> !option_pin_out
        && option_pin_oe == $past(usb_state.charger)) else $error("charger drain wrong");
    frame_toggle_a: assert property (on && clk_en && sel == OPT_FRAME_TOGGLE && usb_state.sof
        |-> ##[1:2] option_pin_out != $past(option_pin_out)) else $error("no toggle");
    vbus_sense_a: assert property (on && sel == OPT_VBUS_SENSE |-> !option_pin_oe
        && vbus_present == $past(option_pin_in)) else $error("vbus sense wrong");
    stay_awake_a: assert property (on && sel == OPT_STAY_AWAKE |-> !option_pin_oe
        && hold_awake == !$past(option_pin_in)) else $error("stay awake wrong");
    cover property (on && sel == OPT_FRAME_TOGGLE && usb_state.sof);
    cover property (on && sel == OPT_POWER_EN && option_pin_oe);
    cover property (on && hold_awake);
endmodule : pin_select_properties
bind config_pin_function_select pin_select_properties u_props (.pclk, .presetn, .clk_en,
    .option_store, .usb_state, .source_sig, .option_pin_in, .option_pin_out,
    .option_pin_oe, .vbus_present, .hold_awake);
`default_nettype wire

// >>> rtl/config_pin_function_select.sv
// Behaviour
// - Pin function comes from the option store word, never from software registers.
// - Tristate disables driver; constant options drive fixed one or zero.
// - Power enable pulls pin low once USB configuration completes.
// - Power enable releases pin high during USB suspend.
// - Power enable is open drain, pulling low only.
// - Sleep indicator drives low in suspend, high otherwise.
// - With cancel set, sleep indicator is high while charger detected.
// - Clock options output fast, mid or slow clock, stopped in suspend.
// - GPIO option makes the pin a software bit-bang input/output.
// - Charger option drives high while dedicated charger detected.
// - Inverted charger option pulls low, open drain, while charger detected.
// - Write strobe option outputs the active-low bit-bang write strobe.
// - Read strobe option outputs the active-low bit-bang read strobe.
// - Bus power sense option takes pin as VBUS-present input.
// - Frame toggle option inverts the pin on each start-of-frame.
// - Stay awake option: low input blocks entry into suspend.
// - Reset low holds every function in reset.
`timescale 1ns/1ns
`default_nettype none
module config_pin_function_select
    import pin_function_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [DATA_W-1:0] pwdata,
    output logic [DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire opt_cfg_s option_store,
    input wire usb_state_s usb_state,
    input wire source_sig_s source_sig,
    input wire logic option_pin_in,
    output logic option_pin_out,
    output logic option_pin_oe,
    output logic vbus_present,
    output logic hold_awake
);

    logic loaded_ff;
    opt_cfg_s cfg_ff;
    logic [EVT_W-1:0] status_ff;
    logic [EVT_W-1:0] mask_ff;
    logic [1:0] gpio_ff;
    logic toggle_ff;
    logic charger_d_ff;
    logic susp_d_ff;
    logic vbus_d_ff;
    logic pin_out_ff;
    logic pin_oe_ff;
    logic vbus_ff;
    logic awake_ff;
    logic irq_ff;
    logic pready_ff;
    logic pslverr_ff;
    logic [DATA_W-1:0] prdata_ff;
    logic nxt_out;
    logic nxt_oe;
    logic [DATA_W-1:0] nxt_rdata;
    logic nxt_err;
    logic [EVT_W-1:0] evt;
    logic setup_phase;
    logic wr_access;

    assign setup_phase = psel && !penable;
    assign wr_access = psel && penable && pready_ff && pwrite;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            loaded_ff <= 1'b0;
            cfg_ff <= '{cancel_sleep: 1'b0, sel: OPT_TRISTATE};
        end else if (clk_en && !loaded_ff) begin
            loaded_ff <= 1'b1;
            cfg_ff <= option_store;
        end
    end

    always_comb begin
        nxt_out = 1'b0;
        nxt_oe = 1'b0;
        unique case (cfg_ff.sel)
            OPT_TRISTATE: begin
                nxt_oe = 1'b0;
            end
            OPT_DRIVE_1: begin
                nxt_out = 1'b1;
                nxt_oe = 1'b1;
            end
            OPT_DRIVE_0: begin
                nxt_oe = 1'b1;
            end
            OPT_POWER_EN: begin
                nxt_oe = usb_state.configured && !usb_state.suspended;
            end
            OPT_SLEEP_IND: begin
                nxt_out = !usb_state.suspended || (cfg_ff.cancel_sleep && usb_state.charger);
                nxt_oe = 1'b1;
            end
            OPT_CLK_FAST: begin
                nxt_out = source_sig.clk_fast && !usb_state.suspended;
                nxt_oe = 1'b1;
            end
            OPT_CLK_MID: begin
                nxt_out = source_sig.clk_mid && !usb_state.suspended;
                nxt_oe = 1'b1;
            end
            OPT_CLK_SLOW: begin
                nxt_out = source_sig.clk_slow && !usb_state.suspended;
                nxt_oe = 1'b1;
            end
            OPT_GPIO: begin
                nxt_out = gpio_ff[GPIO_OUT_BIT];
                nxt_oe = gpio_ff[GPIO_OE_BIT];
            end
            OPT_CHARGER: begin
                nxt_out = usb_state.charger;
                nxt_oe = 1'b1;
            end
            OPT_CHARGER_N: begin
                nxt_oe = usb_state.charger;
            end
            OPT_WRITE_STROBE: begin
                nxt_out = source_sig.strobe_wr_n;
                nxt_oe = 1'b1;
            end
            OPT_READ_STROBE: begin
                nxt_out = source_sig.strobe_rd_n;
                nxt_oe = 1'b1;
            end
            OPT_VBUS_SENSE: begin
                nxt_oe = 1'b0;
            end
            OPT_FRAME_TOGGLE: begin
                nxt_out = toggle_ff;
                nxt_oe = 1'b1;
            end
            OPT_STAY_AWAKE: begin
                nxt_oe = 1'b0;
            end
        endcase
        if (!loaded_ff) begin
            nxt_out = 1'b0;
            nxt_oe = 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_out_ff <= 1'b0;
            pin_oe_ff <= 1'b0;
        end else if (clk_en) begin
            pin_out_ff <= nxt_out;
            pin_oe_ff <= nxt_oe;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            toggle_ff <= 1'b0;
        end else if (clk_en && usb_state.sof) begin
            toggle_ff <= !toggle_ff;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vbus_ff <= 1'b0;
        end else if (clk_en) begin
            vbus_ff <= loaded_ff && (cfg_ff.sel == OPT_VBUS_SENSE) && option_pin_in;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            awake_ff <= 1'b0;
        end else if (clk_en) begin
            awake_ff <= loaded_ff && (cfg_ff.sel == OPT_STAY_AWAKE) && !option_pin_in;
        end
    end

    // Event edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            charger_d_ff <= 1'b0;
            susp_d_ff <= 1'b0;
            vbus_d_ff <= 1'b0;
        end else if (clk_en) begin
            charger_d_ff <= usb_state.charger;
            susp_d_ff <= usb_state.suspended;
            vbus_d_ff <= vbus_ff;
        end
    end

    always_comb begin
        evt = '0;
        evt[EVT_SOF] = usb_state.sof;
        evt[EVT_CHARGER] = usb_state.charger && !charger_d_ff;
        evt[EVT_SUSPEND] = usb_state.suspended && !susp_d_ff;
        evt[EVT_VBUS] = vbus_ff != vbus_d_ff;
    end

    // Sticky status, set beats clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_ff <= RST_STATUS;
        end else if (clk_en) begin
            if (wr_access && paddr == OFS_STATUS) begin
                status_ff <= (status_ff & ~pwdata[EVT_W-1:0]) | evt;
            end else begin
                status_ff <= status_ff | evt;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mask_ff <= RST_MASK;
        end else if (clk_en && wr_access && paddr == OFS_MASK) begin
            mask_ff <= pwdata[EVT_W-1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gpio_ff <= RST_GPIO;
        end else if (clk_en && wr_access && paddr == OFS_GPIO) begin
            gpio_ff <= pwdata[1:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_ff <= 1'b0;
        end else if (clk_en) begin
            irq_ff <= |(status_ff & mask_ff);
        end
    end

    // APB read mux and decode
    always_comb begin
        nxt_rdata = '0;
        nxt_err = 1'b0;
        unique case (paddr)
            OFS_STATUS: nxt_rdata[EVT_W-1:0] = status_ff;
            OFS_MASK: nxt_rdata[EVT_W-1:0] = mask_ff;
            OFS_GPIO: nxt_rdata[1:0] = gpio_ff;
            OFS_PIN_STATE: begin
                nxt_rdata[ST_PIN_BIT] = option_pin_in;
                nxt_rdata[ST_VBUS_BIT] = vbus_ff;
                nxt_rdata[ST_AWAKE_BIT] = awake_ff;
                nxt_rdata[ST_LOADED_BIT] = loaded_ff;
                nxt_rdata[ST_OPT_LSB +: 4] = cfg_ff.sel;
                nxt_rdata[ST_CANCEL_BIT] = cfg_ff.cancel_sleep;
                nxt_rdata[ST_CHARGER_BIT] = usb_state.charger;
                nxt_rdata[ST_SUSP_BIT] = usb_state.suspended;
                nxt_rdata[ST_CONF_BIT] = usb_state.configured;
            end
            default: nxt_err = 1'b1;
        endcase
    end

    // One wait-free access cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_ff <= 1'b0;
            pslverr_ff <= 1'b0;
            prdata_ff <= '0;
        end else if (clk_en) begin
            pready_ff <= setup_phase;
            pslverr_ff <= setup_phase && nxt_err;
            if (setup_phase && !pwrite) begin
                prdata_ff <= nxt_rdata;
            end else if (!psel) begin
                prdata_ff <= '0;
            end
        end
    end

    assign prdata = prdata_ff;
    assign pready = pready_ff;
    assign pslverr = pslverr_ff;
    assign irq = irq_ff;
    assign option_pin_out = pin_out_ff;
    assign option_pin_oe = pin_oe_ff;
    assign vbus_present = vbus_ff;
    assign hold_awake = awake_ff;

endmodule : config_pin_function_select
`default_nettype wire

// >>> rtl/pin_function_pkg.sv
package pin_function_pkg;

    // Pin function codes held in the option store
    typedef enum logic [3:0] {
        OPT_TRISTATE = 4'h0,
        OPT_DRIVE_1 = 4'h1,
        OPT_DRIVE_0 = 4'h2,
        OPT_POWER_EN = 4'h3,
        OPT_SLEEP_IND = 4'h4,
        OPT_CLK_FAST = 4'h5,
        OPT_CLK_MID = 4'h6,
        OPT_CLK_SLOW = 4'h7,
        OPT_GPIO = 4'h8,
        OPT_CHARGER = 4'h9,
        OPT_CHARGER_N = 4'ha,
        OPT_WRITE_STROBE = 4'hb,
        OPT_READ_STROBE = 4'hc,
        OPT_VBUS_SENSE = 4'hd,
        OPT_FRAME_TOGGLE = 4'he,
        OPT_STAY_AWAKE = 4'hf
    } pin_opt_e;

    typedef struct packed {
        logic cancel_sleep;
        pin_opt_e sel;
    } opt_cfg_s;

    typedef struct packed {
        logic configured;
        logic suspended;
        logic sof;
        logic charger;
    } usb_state_s;

    typedef struct packed {
        logic strobe_wr_n;
        logic strobe_rd_n;
        logic clk_fast;
        logic clk_mid;
        logic clk_slow;
    } source_sig_s;

    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int EVT_W = 4;

    localparam logic [ADDR_W-1:0] OFS_STATUS = 12'h000;
    localparam logic [ADDR_W-1:0] OFS_MASK = 12'h004;
    localparam logic [ADDR_W-1:0] OFS_GPIO = 12'h008;
    localparam logic [ADDR_W-1:0] OFS_PIN_STATE = 12'h00c;

    localparam int EVT_SOF = 0;
    localparam int EVT_CHARGER = 1;
    localparam int EVT_SUSPEND = 2;
    localparam int EVT_VBUS = 3;

    localparam int GPIO_OUT_BIT = 0;
    localparam int GPIO_OE_BIT = 1;

    localparam int ST_PIN_BIT = 0;
    localparam int ST_VBUS_BIT = 1;
    localparam int ST_AWAKE_BIT = 2;
    localparam int ST_LOADED_BIT = 3;
    localparam int ST_OPT_LSB = 4;
    localparam int ST_CANCEL_BIT = 8;
    localparam int ST_CHARGER_BIT = 9;
    localparam int ST_SUSP_BIT = 10;
    localparam int ST_CONF_BIT = 11;

    localparam logic [EVT_W-1:0] RST_STATUS = 4'h0;
    localparam logic [EVT_W-1:0] RST_MASK = 4'h0;
    localparam logic [1:0] RST_GPIO = 2'h0;

endpackage : pin_function_pkg
